/* File: common/slp_pkg.sv */
// Shared constants and carrier types for the speed loop PI controller.
// Assumes one 200 MHz clock, AHB-Lite register access and fixed-point
// signals in units of 0.01 % (10000 means 100.00 %).
// Notes on behaviour
// - Total setpoint sums four speed references.
// - Total setpoint goes out; demand returns.
// - Error is demand minus feedback, every tick.
// - PI output becomes the current demand.
// - PI output clamped between upper, lower limits.
// - Gain 0..200 default 10; Ti default 0.5s.
// - Adaption uses profiled gain and integral time.
// - Profiled below low, original above high, interpolated.
// - Selector: feedback, error or current demand.
// - Selector zero disables profiling entirely.
// - Low speed and current quench current loop.
// - Speed loop keeps running during quench.
// - Slewing multiplies integral time by scale.
// - Feedback derivative fraction added to junction.
// - Integral defeat forces integral term zero.
// - Fast reference sampled per tick, within 105%.
// - Fast reference scaled and optionally inverted.
// - Overspeed alarm at feedback at or above trip level.
// - Standstill bias up to 5% added.
// - Slewing when ramp output-input gap exceeds threshold.
`default_nettype none
package slp_pkg;
	// Register byte offsets, one aligned word each.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PGAIN = 8'h04;
	localparam logic [7:0] OFS_ITIME = 8'h08;
	localparam logic [7:0] OFS_AGAIN = 8'h0C;
	localparam logic [7:0] OFS_AITIME = 8'h10;
	localparam logic [7:0] OFS_BRKLO = 8'h14;
	localparam logic [7:0] OFS_BRKHI = 8'h18;
	localparam logic [7:0] OFS_MAXDEM = 8'h1C;
	localparam logic [7:0] OFS_MINDEM = 8'h20;
	localparam logic [7:0] OFS_OVSPD = 8'h24;
	localparam logic [7:0] OFS_BIAS = 8'h28;
	localparam logic [7:0] OFS_QSPD = 8'h2C;
	localparam logic [7:0] OFS_QCUR = 8'h30;
	localparam logic [7:0] OFS_IRAMP = 8'h34;
	localparam logic [7:0] OFS_RTHR = 8'h38;
	localparam logic [7:0] OFS_RATIO = 8'h3C;
	localparam logic [7:0] OFS_SP4 = 8'h40;
	localparam logic [7:0] OFS_INERT = 8'h44;
	localparam logic [7:0] OFS_STATUS = 8'h48;
	localparam logic [7:0] OFS_CURDEM = 8'h4C;
	localparam logic [7:0] OFS_TOTAL = 8'h50;
	localparam logic [7:0] OFS_ERROR = 8'h54;
	localparam int NREG = 22;
	// Control word fields.
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_DEFEAT = 2;
	localparam int CTRL_INVERT = 3;
	// Reset values (decimal meaning in the comment).
	localparam logic [15:0] RST_PGAIN = 16'h03E8; // 10.00
	localparam logic [15:0] RST_ITIME = 16'h01F4; // 500 ms
	localparam logic [15:0] RST_AGAIN = 16'h01F4; // 5.00
	localparam logic [15:0] RST_AITIME = 16'h01F4; // 500 ms
	localparam logic [15:0] RST_BRKLO = 16'h0064; // 1.00 %
	localparam logic [15:0] RST_BRKHI = 16'h01F4; // 5.00 %
	localparam logic [15:0] RST_MAXDEM = 16'h2904; // 105.00 %
	localparam logic [15:0] RST_MINDEM = 16'hD6FC; // -105.00 %
	localparam logic [15:0] RST_OVSPD = 16'h2E18; // 118.00 %
	localparam logic [15:0] RST_QSPD = 16'h0032; // 0.50 %
	localparam logic [15:0] RST_QCUR = 16'h0096; // 1.50 %
	localparam logic [15:0] RST_IRAMP = 16'h2710; // 10000
	localparam logic [15:0] RST_RTHR = 16'h0032; // 0.50 %
	localparam logic [15:0] RST_RATIO = 16'h2710; // ratio 1.0000
	// Signal limits.
	localparam int SP_LIM = 32'h0000_2EE0; // 120.00 %
	localparam int FAST_LIM = 32'h0000_2904; // 105.00 %
	localparam int BIAS_LIM = 32'h0000_01F4; // 5.00 %
	localparam int FRAC_BITS = 12;
	// Loop tick period in microseconds.
	localparam int TICK_US = 32'h0000_03E8;
	// Inputs from the surrounding function blocks.
	typedef struct packed {
		logic signed [15:0] sum_ref;
		logic signed [15:0] ramp_out;
		logic signed [15:0] ramp_in;
		logic signed [15:0] fast_ref;
		logic signed [15:0] demand;
		logic signed [15:0] feedback;
	} slp_refs_t;
	// Results towards current loop and stop sequencing.
	typedef struct packed {
		logic signed [15:0] total_sp;
		logic signed [15:0] current_demand;
		logic signed [15:0] speed_error;
		logic quench;
		logic overspeed;
		logic slewing;
		logic cur_loop_en;
	} slp_loop_t;
endpackage
`default_nettype wire

/* File: rtl/slp_speed_loop.sv */
// Speed loop PI controller with AHB-Lite register slave.
// Assumes loop_tick and the reference inputs come from logic on sys_clk.
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`default_nettype none
module slp_speed_loop import slp_pkg::*; #(
	parameter int TICK_PERIOD_US = TICK_US
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Loop side.
	input wire logic loop_tick,
	input wire slp_refs_t refs_i,
	output slp_loop_t loop_o
);
	typedef logic signed [63:0] slp_wide_t;

	// Refuse periods the integrator arithmetic cannot serve.
	if (TICK_PERIOD_US < 1 || TICK_PERIOD_US > 100000) begin : g_chk
		$error("tick period out of range");
	end

	// Register storage, indexed by word address.
	logic [15:0] regs_q [NREG];
	logic wr_pend_q;
	logic [4:0] wr_idx_q;
	logic [31:0] rd_q;

	// Loop state, updated once per tick.
	logic signed [15:0] total_q, err_q, out_q, fb_prev_q;
	slp_wide_t acc_q;
	logic quench_q, ovs_q, slew_q;

	// Saturate a wide value into a 16-bit range.
	function automatic logic signed [15:0] sat(slp_wide_t v, slp_wide_t lo, slp_wide_t hi);
		if (v > hi) begin
			return hi[15:0];
		end
		if (v < lo) begin
			return lo[15:0];
		end
		return v[15:0];
	endfunction

	// Magnitude of a signed sample.
	function automatic slp_wide_t mag(slp_wide_t v);
		return (v < 0) ? -v : v;
	endfunction

	// Interpolate between profiled and original value over the band.
	function automatic slp_wide_t interp(slp_wide_t a, slp_wide_t o, slp_wide_t x,
			slp_wide_t lo, slp_wide_t hi, logic off);
		if (off || x >= hi) begin
			return o;
		end
		if (x <= lo) begin
			return a;
		end
		return a + ((o - a) * (x - lo)) / (hi - lo);
	endfunction

	// Signed view of a stored register.
	function automatic slp_wide_t sv(logic [15:0] r);
		return slp_wide_t'($signed(r));
	endfunction

	// Reset value of each register word.
	function automatic logic [15:0] rst_val(int i);
		case (i)
			OFS_PGAIN[6:2]: return RST_PGAIN;
			OFS_ITIME[6:2]: return RST_ITIME;
			OFS_AGAIN[6:2]: return RST_AGAIN;
			OFS_AITIME[6:2]: return RST_AITIME;
			OFS_BRKLO[6:2]: return RST_BRKLO;
			OFS_BRKHI[6:2]: return RST_BRKHI;
			OFS_MAXDEM[6:2]: return RST_MAXDEM;
			OFS_MINDEM[6:2]: return RST_MINDEM;
			OFS_OVSPD[6:2]: return RST_OVSPD;
			OFS_QSPD[6:2]: return RST_QSPD;
			OFS_QCUR[6:2]: return RST_QCUR;
			OFS_IRAMP[6:2]: return RST_IRAMP;
			OFS_RTHR[6:2]: return RST_RTHR;
			OFS_RATIO[6:2]: return RST_RATIO;
			default: return 16'h0000;
		endcase
	endfunction

	// Address phase decode; only whole-word transfers are expected.
	logic acc_ph, map_ok;
	logic [4:0] a_idx;
	assign acc_ph = hsel && hready && htrans[1];
	assign a_idx = haddr[6:2];
	assign map_ok = (haddr[31:7] == 25'h0) && (int'(a_idx) < NREG);

	// The slave never stretches and never errors.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rd_q;

	// Write address is held for the data phase that follows.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 5'h00;
		end else begin
			wr_pend_q <= acc_ph && hwrite && map_ok && a_idx < OFS_STATUS[6:2];
			wr_idx_q <= a_idx;
		end
	end

	// Settings storage; status words above the settings are read only.
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NREG; i++) begin
			if (!nrst) begin
				regs_q[i] <= rst_val(i);
			end else if (wr_pend_q && int'(wr_idx_q) == i) begin
				regs_q[i] <= hwdata[15:0];
			end
		end
	end

	// Read value; a write landing this cycle is forwarded so a
	// back-to-back read of the same word sees the new value.
	logic [15:0] rd_word;
	always_comb begin
		rd_word = regs_q[a_idx];
		if (wr_pend_q && wr_idx_q == a_idx) begin
			rd_word = hwdata[15:0];
		end
		case (a_idx)
			OFS_STATUS[6:2]: rd_word = {12'h000, loop_o.cur_loop_en, slew_q, ovs_q, quench_q};
			OFS_CURDEM[6:2]: rd_word = out_q;
			OFS_TOTAL[6:2]: rd_word = total_q;
			OFS_ERROR[6:2]: rd_word = err_q;
			default: ;
		endcase
	end

	// Read data is captured at the address phase; unmapped reads give zero.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rd_q <= 32'h0000_0000;
		end else if (acc_ph && !hwrite) begin
			rd_q <= map_ok ? {{16{rd_word[15]}}, rd_word} : 32'h0000_0000;
		end
	end

	// Loop arithmetic for the current tick.
	logic signed [15:0] fast_c, fb_c, total_c, err_c, out_c;
	slp_wide_t fast_s, kp, ti, den, inc, acc_c, p_t, in_t, src, lo_l, hi_l;
	logic mode_off, slew_c;
	always_comb begin
		lo_l = sv(regs_q[OFS_MINDEM[6:2]]);
		hi_l = sv(regs_q[OFS_MAXDEM[6:2]]);
		// Fast reference clamp, ratio and sign.
		fast_c = sat(slp_wide_t'(refs_i.fast_ref), -FAST_LIM, FAST_LIM);
		fast_s = (slp_wide_t'(fast_c) * sv(regs_q[OFS_RATIO[6:2]])) / 10000;
		if (regs_q[OFS_CTRL[6:2]][CTRL_INVERT]) begin
			fast_s = -fast_s;
		end
		total_c = sat(slp_wide_t'(refs_i.sum_ref) + slp_wide_t'(refs_i.ramp_out) + fast_s
			+ sv(regs_q[OFS_SP4[6:2]]), -SP_LIM, SP_LIM);
		// Standstill bias on feedback, itself limited.
		fb_c = sat(slp_wide_t'(refs_i.feedback)
			+ sat(sv(regs_q[OFS_BIAS[6:2]]), -BIAS_LIM, BIAS_LIM), -32767, 32767);
		err_c = sat(slp_wide_t'(refs_i.demand) - slp_wide_t'(fb_c), -32767, 32767);
		// Profiling source.
		mode_off = regs_q[OFS_CTRL[6:2]][CTRL_MODE_LSB +: 2] == 2'd0;
		case (regs_q[OFS_CTRL[6:2]][CTRL_MODE_LSB +: 2])
			2'd1: src = mag(slp_wide_t'(fb_c));
			2'd2: src = mag(slp_wide_t'(err_c));
			2'd3: src = mag(slp_wide_t'(out_q));
			default: src = 0;
		endcase
		kp = interp(sv(regs_q[OFS_AGAIN[6:2]]), sv(regs_q[OFS_PGAIN[6:2]]), src,
			sv(regs_q[OFS_BRKLO[6:2]]), sv(regs_q[OFS_BRKHI[6:2]]), mode_off);
		ti = interp(sv(regs_q[OFS_AITIME[6:2]]), sv(regs_q[OFS_ITIME[6:2]]), src,
			sv(regs_q[OFS_BRKLO[6:2]]), sv(regs_q[OFS_BRKHI[6:2]]), mode_off);
		// Slewing stretches the integral time by the scale factor.
		slew_c = mag(slp_wide_t'(refs_i.ramp_out) - slp_wide_t'(refs_i.ramp_in))
			> sv(regs_q[OFS_RTHR[6:2]]);
		den = 10 * ((ti < 1) ? 1 : ti) * (slew_c ? sv(regs_q[OFS_IRAMP[6:2]]) : 10000);
		if (den < 1) begin
			den = 1;
		end
		inc = (kp * slp_wide_t'(err_c) * TICK_PERIOD_US * (64'sd1 <<< FRAC_BITS)) / den;
		acc_c = acc_q + inc;
		// Integrator clamps at the output limits to stop windup.
		if (acc_c > (hi_l <<< FRAC_BITS)) begin
			acc_c = hi_l <<< FRAC_BITS;
		end
		if (acc_c < (lo_l <<< FRAC_BITS)) begin
			acc_c = lo_l <<< FRAC_BITS;
		end
		if (regs_q[OFS_CTRL[6:2]][CTRL_DEFEAT]) begin
			acc_c = 0;
		end
		p_t = (kp * slp_wide_t'(err_c)) / 100;
		in_t = ((slp_wide_t'(fb_c) - slp_wide_t'(fb_prev_q))
			* sv(regs_q[OFS_INERT[6:2]])) / 100;
		out_c = sat(p_t + (acc_c >>> FRAC_BITS) + in_t, lo_l, hi_l);
	end

	// Loop state advances on the tick only; nothing wraps.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			total_q <= 16'h0000;
			err_q <= 16'h0000;
			out_q <= 16'h0000;
			fb_prev_q <= 16'h0000;
			acc_q <= 64'h0000_0000_0000_0000;
		end else if (loop_tick) begin
			total_q <= total_c;
			err_q <= err_c;
			out_q <= out_c;
			fb_prev_q <= fb_c;
			acc_q <= acc_c;
		end
	end

	// Alarms and quench, evaluated each tick from the fresh values.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			quench_q <= 1'b0;
			ovs_q <= 1'b0;
			slew_q <= 1'b0;
		end else if (loop_tick) begin
			quench_q <= mag(slp_wide_t'(refs_i.demand)) < sv(regs_q[OFS_QSPD[6:2]])
				&& mag(slp_wide_t'(fb_c)) < sv(regs_q[OFS_QSPD[6:2]])
				&& mag(slp_wide_t'(out_c)) < sv(regs_q[OFS_QCUR[6:2]]);
			ovs_q <= mag(slp_wide_t'(fb_c)) >= sv(regs_q[OFS_OVSPD[6:2]]);
			slew_q <= slew_c;
		end
	end

	// Quench only gates the current loop; the PI keeps running.
	always_comb begin
		loop_o.total_sp = total_q;
		loop_o.current_demand = out_q;
		loop_o.speed_error = err_q;
		loop_o.quench = quench_q;
		loop_o.overspeed = ovs_q;
		loop_o.slewing = slew_q;
		loop_o.cur_loop_en = !quench_q;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// Output stays within the programmed limits.
	out_limits_a: assert property (##1 slp_wide_t'(out_q) <= hi_l
		&& slp_wide_t'(out_q) >= lo_l || $changed(regs_q[OFS_MAXDEM[6:2]])
		|| $changed(regs_q[OFS_MINDEM[6:2]])) else $error("output outside limits");
	// Error register tracks demand minus feedback after a tick.
	err_update_a: assert property (loop_tick |=> err_q == $past(err_c))
		else $error("speed error not updated");
	// Loop state holds between ticks.
	tick_hold_a: assert property (!loop_tick |=> $stable(out_q) && $stable(acc_q))
		else $error("loop state moved without tick");
	// Integral defeat leaves no integral state after a tick.
	defeat_zero_a: assert property (loop_tick && regs_q[OFS_CTRL[6:2]][CTRL_DEFEAT]
		|=> acc_q == 0) else $error("integral not zero under defeat");
	// Quench drops the current loop enable but not the PI.
	quench_gate_a: assert property (quench_q |-> !loop_o.cur_loop_en)
		else $error("current loop enabled during quench");
	// Overspeed follows feedback against the trip level.
	ovs_trip_a: assert property (loop_tick && mag(slp_wide_t'(fb_c))
		>= sv(regs_q[OFS_OVSPD[6:2]]) |=> ovs_q) else $error("overspeed missed");
	// Total setpoint never exceeds 120 %.
	total_range_a: assert property (total_q <= SP_LIM && total_q >= -SP_LIM)
		else $error("total setpoint out of range");
	// Slewing flag reflects the ramp gap after a tick.
	slew_flag_a: assert property (loop_tick |=> slew_q == $past(slew_c))
		else $error("slewing flag wrong");

	// Total setpoint register follows the summed references after a tick.
	total_update_a: assert property (loop_tick |=> total_q == $past(total_c))
		else $error("total setpoint not updated");
	// Current demand follows the clamped PI result after a tick.
	cur_demand_a: assert property (loop_tick |=> out_q == $past(out_c))
		else $error("current demand not updated");
	// A demand at or above the quench speed level never leaves quench set.
	quench_cond_a: assert property (loop_tick && mag(slp_wide_t'(refs_i.demand))
		>= sv(regs_q[OFS_QSPD[6:2]]) |=> !quench_q) else $error("quench at speed");
	// The feedback history used for inertia compensation moves only on a tick.
	fb_hist_a: assert property (!loop_tick |=> $stable(fb_prev_q))
		else $error("feedback history moved without tick");
	// The fast reference is held within its own limit before the ratio scales it into the sum.
	fast_clamp_a: assert property (fast_c <= FAST_LIM && fast_c >= -FAST_LIM)
		else $error("fast reference outside limit");
	// Alarm and slew flags also hold between ticks.
	flag_hold_a: assert property (!loop_tick |=> $stable(ovs_q) && $stable(slew_q))
		else $error("flags moved without tick");
	// Profiling switched off always selects the original gain.
	gain_orig_a: assert property (mode_off |-> kp == sv(regs_q[OFS_PGAIN[6:2]]))
		else $error("profiled gain used with profiling off");
	// Reads of unmapped words return zero data.
	unmapped_zero_a: assert property (acc_ph && !hwrite && !map_ok |=> rd_q == 32'h0000_0000)
		else $error("unmapped read not zero");
	// The current loop enable is the inverse of quench at all times.
	loop_en_a: assert property (loop_o.cur_loop_en == !quench_q)
		else $error("loop enable disagrees with quench");
	// The integral divisor never reaches zero, whatever the scale factor.
	den_pos_a: assert property (den >= 1)
		else $error("integral divisor not positive");
	// Status words are never the target of a pending write.
	status_ro_a: assert property (wr_pend_q |-> wr_idx_q < OFS_STATUS[6:2])
		else $error("write aimed at a status word");

	// Coverage of the main scenarios: quench entry, overspeed, profiling,
	// integral defeat and ramp slewing. A scenario that never shows here
	// leaves the matching assertion above without a live antecedent.
	quench_seen_c: cover property (!quench_q ##1 quench_q);
	defeat_seen_c: cover property (loop_tick && regs_q[OFS_CTRL[6:2]][CTRL_DEFEAT]);
	slew_seen_c: cover property (loop_tick ##1 slew_q);
	ovs_seen_c: cover property (loop_tick ##1 ovs_q);
	adapt_band_c: cover property (loop_tick && !mode_off && src > 0);
endmodule
`default_nettype wire

/* File: verif/slp_far_model.sv */
// Far-side model: the network setpoint source and the stop-sequencing block.
// Assumes no stop is in progress, so the demand handed back is the total setpoint.
`default_nettype none
module slp_far_model import slp_pkg::*; (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic nrst,
	// Network reference in, loop results back.
	input wire logic signed [15:0] net_ref,
	input wire slp_loop_t loop_i,
	// Values handed to the loop.
	output logic signed [15:0] sum_ref,
	output logic signed [15:0] demand
);
	// Network values are prescaled by 0.8333 so that a full network reference gives 83.33 % and leaves headroom.
	always_comb begin
		sum_ref = 16'(int'(net_ref) * 8333 / 10000);
	end
	// While running, the stop ramp is idle and the total passes straight back as demand.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			demand <= '0;
		end else begin
			demand <= loop_i.total_sp;
		end
	end
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the speed loop: register accesses and paired loop ticks.
// Assumes the far-side model returns the total setpoint as the demand.
`default_nettype none
module testbench import slp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// Expected loop results for one checked tick.
	typedef struct packed {int tot; int err; int cd; logic cdv; logic ov; logic sl; logic q;} slp_exp_t;
	// Bus, loop and far-side signals.
	logic sys_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, loop_tick = 1'b0;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic hreadyout, hresp, rd_ph = 1'b0, lchk = 1'b0, tick_d = 1'b0;
	logic signed [15:0] net_ref = '0, sum_ref, demand;
	slp_refs_t bref = '0, refs;
	slp_loop_t loop_o;
	// Notes of expected results, oldest first.
	logic [31:0] rd_q [$];
	slp_exp_t lp_q [$];
	int fail_count = 0, total_checks = 0;
	// Shadow of the settings the bench has written.
	int sp4 = 0, ratio = 10000, inv = 0, dft = 0, mode = 0, bias = 0;
	logic [7:0] rofs [16] = '{OFS_CTRL, OFS_PGAIN, OFS_ITIME, OFS_AGAIN, OFS_AITIME, OFS_BRKLO,
		OFS_BRKHI, OFS_MAXDEM, OFS_MINDEM, OFS_OVSPD, OFS_QSPD, OFS_QCUR, OFS_IRAMP, OFS_RTHR,
		OFS_RATIO, OFS_BIAS};
	logic [15:0] rval [16] = '{16'h0000, RST_PGAIN, RST_ITIME, RST_AGAIN, RST_AITIME, RST_BRKLO,
		RST_BRKHI, RST_MAXDEM, RST_MINDEM, RST_OVSPD, RST_QSPD, RST_QCUR, RST_IRAMP, RST_RTHR,
		RST_RATIO, 16'h0000};
	// A 5 ns clock.
	always #2.5 sys_clk = ~sys_clk;
	// The far side owns the summed reference and the demand.
	always_comb begin
		refs = bref;
		refs.sum_ref = sum_ref;
		refs.demand = demand;
	end
	slp_speed_loop dut_u (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .loop_tick(loop_tick),
		.refs_i(refs), .loop_o(loop_o));
	slp_far_model far_u (.sys_clk(sys_clk), .nrst(nrst), .net_ref(net_ref), .loop_i(loop_o),
		.sum_ref(sum_ref), .demand(demand));
	// Counts one comparison and reports a miss at once.
	task automatic chk(input logic ok, input string what);
		total_checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Watcher: a read answer lands at the end of its data phase, loop results a cycle after a tick.
	always @(posedge sys_clk) begin
		slp_exp_t e;
		if (rd_ph && hreadyout) begin
			chk(hrdata === rd_q.pop_front() && hresp === 1'b0, "read data");
		end
		if (tick_d) begin
			e = lp_q.pop_front();
			chk(loop_o.total_sp === 16'(e.tot), "total setpoint");
			chk(loop_o.speed_error === 16'(e.err), "speed error");
			chk(!e.cdv || loop_o.current_demand === 16'(e.cd), "current demand");
			chk(loop_o.overspeed === e.ov && loop_o.slewing === e.sl, "flags");
			chk(!e.cdv || loop_o.quench === e.q, "quench");
			chk(loop_o.cur_loop_en === !loop_o.quench, "loop enable");
		end
		tick_d <= loop_tick & lchk;
	end
	// Waits for hready under a bound, so a stuck slave cannot hang the run.
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
	endtask
	// One single word transfer: address phase, then data phase.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= 32'(a);
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		rd_ph <= !wr;
		wait_rdy();
		rd_ph <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		rd_q.push_back(exp);
		bus(1'b0, a, 32'h0000_0000);
	endtask
	// Two ticks with the same references; the second sees the returned demand and is checked.
	task automatic step(input int net, ramp, rin, fast, fb);
		slp_exp_t e;
		int fs;
		fs = fast * ratio / 10000;
		fs = inv ? -fs : fs;
		e.tot = net * 8333 / 10000 + ramp + fs + sp4;
		e.tot = e.tot > SP_LIM ? SP_LIM : (e.tot < -SP_LIM ? -SP_LIM : e.tot);
		e.err = e.tot - fb - (bias > 500 ? 500 : bias);
		e.cd = dft ? e.err * ((mode != 0) ? 500 : 1000) / 100
			: (e.err > 0 ? 10500 : -10500);
		e.cdv = dft || e.err > 2100 || e.err < -2100;
		e.ov = fb >= 11800;
		e.sl = (ramp - rin > 50) || (rin - ramp > 50);
		e.q = e.tot * e.tot < 2500 && fb * fb < 2500 && e.cd * e.cd < 22500;
		bref.ramp_out <= 16'(ramp);
		bref.ramp_in <= 16'(rin);
		bref.fast_ref <= 16'(fast);
		bref.feedback <= 16'(fb);
		net_ref <= 16'(net);
		loop_tick <= 1'b1;
		@(posedge sys_clk);
		loop_tick <= 1'b0;
		repeat (2) @(posedge sys_clk);
		lp_q.push_back(e);
		loop_tick <= 1'b1;
		lchk <= 1'b1;
		@(posedge sys_clk);
		loop_tick <= 1'b0;
		lchk <= 1'b0;
		repeat (2) @(posedge sys_clk);
	endtask
	// Main sequence.
	initial begin
		void'($urandom(50322));
		repeat (6) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			rd(rofs[i], {{16{rval[i][15]}}, rval[i]});
		end
		rd(8'h80, 32'h0000_0000);
		wr(OFS_STATUS, 32'h0000_000F);
		rd(OFS_STATUS, 32'h0000_0008);
		sp4 = int'($urandom_range(2000)) - 1000;
		wr(OFS_SP4, 32'(sp4));
		rd(OFS_SP4, 32'(sp4));
		step(12000, 5000, 5000, 0, 0);
		step(-6000, -4000, -4000, -3000, 2000);
		step(0, 0, 0, 0, 11800);
		step(0, 0, 0, 0, 11799);
		step(0, 100, 49, 0, 0);
		step(0, 100, 50, 0, 0);
		bias = 700;
		wr(OFS_BIAS, 32'h0000_02BC);
		step(12000, 0, 0, 0, 100);
		bias = 0;
		wr(OFS_BIAS, 32'h0000_0000);
		ratio = 5000;
		inv = 1;
		wr(OFS_RATIO, 32'h0000_1388);
		wr(OFS_CTRL, 32'h0000_0008);
		step(0, 0, 0, 3000, 0);
		ratio = 10000;
		inv = 0;
		wr(OFS_RATIO, 32'h0000_2710);
		dft = 1;
		sp4 = 20;
		wr(OFS_SP4, 32'h0000_0014);
		// Every adaption mode with integral defeat on; each source sits at or below the low breakpoint.
		for (int m = 0; m < 4; m++) begin
			mode = m;
			wr(OFS_CTRL, 32'(4 + m));
			rd(OFS_CTRL, 32'(4 + m));
			step(0, 0, 0, 0, 0);
		end
		mode = 0;
		sp4 = 10;
		wr(OFS_CTRL, 32'h0000_0004);
		wr(OFS_SP4, 32'h0000_000A);
		step(0, 0, 0, 0, 0);
		close_out();
	end
	// Watchdog: the sequence needs well under a thousand cycles, so 4000 means a hang.
	initial begin
		#20000;
		fail_count++;
		$display("mismatch at %0t: run did not finish", $time);
		close_out();
	end
endmodule
`default_nettype wire
